// *** design/msa_pkg.sv ***
// Shared constants and types for the math accelerator controller.
// Assumes the accelerator registers sit on a byte-wide register port clocked by ref_clk.
package msa_pkg;

    // ------------------------------------------------------------
    // Register addresses on the accelerator port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SHIFT_CNT = 8'hd1;
    localparam logic [7:0] ADDR_CTRL_STAT = 8'hd2;
    localparam logic [7:0] ADDR_OPA = 8'hd3;
    localparam logic [7:0] ADDR_OPB = 8'hd4;
    localparam logic [7:0] ADDR_ACC = 8'hd5;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int BUSY_BIT = 7;
    localparam int MAC_BIT = 6;
    localparam int CNT_W = 5;
    localparam logic [7:0] CTRL_CLEAR_VAL = 8'h00;

    // Write data sources: bytes of a, b, acc, the count setup, and zero.
    localparam logic [3:0] SRC_A0 = 4'h0;
    localparam logic [3:0] SRC_B0 = 4'h4;
    localparam logic [3:0] SRC_ACC0 = 4'h6;
    localparam logic [3:0] SRC_CFG = 4'hb;
    localparam logic [3:0] SRC_ZERO = 4'hc;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_MUL = 3'b000,
        OP_DIV32 = 3'b001,
        OP_DIV16 = 3'b010,
        OP_SHIFT = 3'b011,
        OP_NORM = 3'b100,
        OP_ACC_LOAD = 3'b101,
        OP_ACC_READ = 3'b110,
        OP_CLEAR = 3'b111
    } msa_op_t;

    typedef enum logic [2:0] {
        K_WR = 3'b000,
        K_RD = 3'b001,
        K_POLL = 3'b010,
        K_ACCCHK = 3'b011,
        K_END = 3'b100
    } msa_kind_t;

    typedef enum logic [1:0] {
        D_RES = 2'b00,
        D_REM = 2'b01,
        D_ACC = 2'b10,
        D_EXP = 2'b11
    } msa_dst_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ISSUE = 2'b01,
        S_WAIT = 2'b10,
        S_DONE = 2'b11
    } msa_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        msa_kind_t kind;
        logic [7:0] addr;
        logic [3:0] src;
        msa_dst_t dst;
    } msa_step_t;

    typedef struct packed {
        msa_op_t op;
        logic [31:0] a;
        logic [15:0] b;
        logic [CNT_W-1:0] cnt;
        logic dir;
        logic [39:0] acc;
    } msa_cmd_t;

    typedef struct packed {
        logic [31:0] res;
        logic [15:0] rem;
        logic [CNT_W-1:0] exp;
        logic [39:0] acc;
    } msa_rsp_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msa_sfr_t;

endpackage

// *** design/msa_step_rom.sv ***
// Access sequence table: the register access to make at each step of an operation.
// Assumes the caller walks the index from zero and stops at the end step.
`timescale 1ns/1ps
module msa_step_rom
    import msa_pkg::*;
(
    input wire msa_op_t op,
    input wire logic [3:0] idx,
    output msa_step_t step
);

    // ------------------------------------------------------------
    // Step builder
    // ------------------------------------------------------------
    // Packs one step record.
    function automatic msa_step_t mk(input msa_kind_t k, input logic [7:0] a,
                                     input logic [3:0] s, input msa_dst_t d);
        msa_step_t r;
        r.kind = k;
        r.addr = a;
        r.src = s;
        r.dst = d;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // The operation is implied by the access order and, for normalize, by a zero count; no opcode is written.
    always_comb begin
        step = mk(K_END, ADDR_OPA, SRC_ZERO, D_RES);
        case (op)
            OP_MUL: begin
                if (idx < 4'd2) step = mk(K_WR, ADDR_OPB, SRC_B0 + idx, D_RES);
                else if (idx < 4'd4) step = mk(K_WR, ADDR_OPA, idx - 4'd2, D_RES);
                else if (idx == 4'd4) step = mk(K_POLL, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
                else if (idx < 4'd9) step = mk(K_RD, ADDR_OPA, SRC_ZERO, D_RES);
            end
            OP_DIV32: begin
                if (idx < 4'd4) step = mk(K_WR, ADDR_OPA, idx, D_RES);
                else if (idx < 4'd6) step = mk(K_WR, ADDR_OPB, idx, D_RES);
                else if (idx == 4'd6) step = mk(K_POLL, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
                else if (idx < 4'd11) step = mk(K_RD, ADDR_OPA, SRC_ZERO, D_RES);
                else if (idx < 4'd13) step = mk(K_RD, ADDR_OPB, SRC_ZERO, D_REM);
            end
            OP_DIV16: begin
                if (idx < 4'd2) step = mk(K_WR, ADDR_OPA, idx, D_RES);
                else if (idx < 4'd4) step = mk(K_WR, ADDR_OPB, idx + 4'd2, D_RES);
                else if (idx == 4'd4) step = mk(K_POLL, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
                else if (idx < 4'd7) step = mk(K_RD, ADDR_OPA, SRC_ZERO, D_RES);
                else if (idx < 4'd9) step = mk(K_RD, ADDR_OPB, SRC_ZERO, D_REM);
            end
            OP_SHIFT, OP_NORM: begin
                if (idx < 4'd4) step = mk(K_WR, ADDR_OPA, idx, D_RES);
                else if (idx == 4'd4) step = mk(K_WR, ADDR_SHIFT_CNT,
                    (op == OP_NORM) ? SRC_ZERO : SRC_CFG, D_RES);
                else if (idx == 4'd5) step = mk(K_POLL, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
                else if (idx < 4'd10) step = mk(K_RD, ADDR_OPA, SRC_ZERO, D_RES);
                else if (idx == 4'd10 && op == OP_NORM)
                    step = mk(K_RD, ADDR_SHIFT_CNT, SRC_ZERO, D_EXP);
            end
            OP_ACC_LOAD: begin
                if (idx == 4'd0) step = mk(K_ACCCHK, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
                else if (idx < 4'd6) step = mk(K_WR, ADDR_ACC, idx + 4'd5, D_RES);
            end
            OP_ACC_READ: begin
                if (idx == 4'd0) step = mk(K_ACCCHK, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
                else if (idx < 4'd6) step = mk(K_RD, ADDR_ACC, SRC_ZERO, D_ACC);
            end
            OP_CLEAR: begin
                if (idx == 4'd0) step = mk(K_WR, ADDR_CTRL_STAT, SRC_ZERO, D_RES);
            end
            default: begin
                step = mk(K_END, ADDR_OPA, SRC_ZERO, D_RES);
            end
        endcase
    end

endmodule

// *** design/msa_sfr_port.sv ***
// Register port driver: turns one access request into strobes on the accelerator port.
// Assumes read data is presented by the accelerator in the cycle after the read strobe.
`timescale 1ns/1ps
module msa_sfr_port
    import msa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic req,
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [7:0] sfr_rdata,
    output msa_sfr_t sfr_out,
    output logic ack,
    output logic [7:0] ack_rdata
);

    typedef struct packed {
        msa_sfr_t pin;
        logic rd_pend;
    } msa_port_state_t;

    msa_port_state_t q_r;
    msa_port_state_t q_nxt;

    // ------------------------------------------------------------
    // Strobe generation
    // ------------------------------------------------------------
    // Strobes last one cycle; a read is answered one cycle later.
    always_comb begin
        q_nxt = q_r;
        q_nxt.pin.wr = 1'b0;
        q_nxt.pin.rd = 1'b0;
        q_nxt.rd_pend = q_r.pin.rd;
        if (req) begin
            q_nxt.pin.wr = req_wr;
            q_nxt.pin.rd = ~req_wr;
            q_nxt.pin.addr = req_addr;
            q_nxt.pin.wdata = req_wdata;
        end
    end

    // State register with clock enable.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q_r <= '0;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    assign sfr_out = q_r.pin;
    assign ack = q_r.pin.wr | q_r.rd_pend; // Write done with its strobe.
    assign ack_rdata = sfr_rdata;

endmodule

// *** design/msa_ctrl.sv ***
// Controller that drives the math accelerator through its register port.
// Assumes the accelerator shares ref_clk and answers reads one cycle after the strobe.
`timescale 1ns/1ps
module msa_ctrl
    import msa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire msa_cmd_t cmd,
    output logic rsp_valid,
    output msa_rsp_t rsp,
    output logic busy,
    output msa_sfr_t sfr_out,
    input wire logic [7:0] sfr_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        msa_state_t st;
        logic [3:0] idx;
        msa_cmd_t cmd;
        msa_rsp_t rsp;
        logic rsp_valid;
        logic seen_clear;
        logic acc_ok;
    } msa_ctrl_state_t;

    msa_ctrl_state_t q_r;
    msa_ctrl_state_t q_nxt;
    msa_step_t step;
    logic port_req;
    logic port_ack;
    logic [7:0] port_rdata;
    logic [7:0] wbyte;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Selects the byte that a write step sends.
    function automatic logic [7:0] pick_byte(input msa_cmd_t c, input logic [3:0] s);
        logic [103:0] v;
        v = {8'h00, {2'b00, c.dir, c.cnt}, c.acc, c.b, c.a};
        if (s > SRC_ZERO) return 8'h00;
        return v[s*8 +: 8];
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    msa_step_rom u_rom (
        .op(q_r.cmd.op),
        .idx(q_r.idx),
        .step(step)
    );

    msa_sfr_port u_port (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .req(port_req),
        .req_wr(step.kind == K_WR),
        .req_addr(step.addr),
        .req_wdata(wbyte),
        .sfr_rdata(sfr_rdata),
        .sfr_out(sfr_out),
        .ack(port_ack),
        .ack_rdata(port_rdata)
    );

    // One access per visit to the issue state; a poll or flag-check step reissues until its flag reads clear.
    assign port_req = (q_r.st == S_ISSUE) && (step.kind != K_END);
    assign wbyte = pick_byte(q_r.cmd, step.src);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Walks the access table, polls flags and gathers read bytes.
    always_comb begin
        q_nxt = q_r;
        q_nxt.rsp_valid = 1'b0;
        case (q_r.st)
            S_IDLE: begin
                if (cmd_valid) begin
                    q_nxt.cmd = cmd;
                    q_nxt.idx = 4'h0;
                    q_nxt.rsp = '0;
                    q_nxt.seen_clear = 1'b0;
                    q_nxt.acc_ok = 1'b0;
                    q_nxt.st = S_ISSUE;
                end
            end
            S_ISSUE: begin
                q_nxt.st = (step.kind == K_END) ? S_DONE : S_WAIT;
            end
            S_WAIT: begin
                if (port_ack) begin
                    q_nxt.st = S_ISSUE;
                    case (step.kind)
                        K_WR: begin
                            q_nxt.idx = q_r.idx + 4'h1;
                        end
                        K_RD: begin
                            q_nxt.idx = q_r.idx + 4'h1;
                            case (step.dst)
                                D_RES: q_nxt.rsp.res = {q_r.rsp.res[23:0], port_rdata};
                                D_REM: q_nxt.rsp.rem = {q_r.rsp.rem[7:0], port_rdata};
                                D_ACC: q_nxt.rsp.acc = {q_r.rsp.acc[31:0], port_rdata};
                                default: q_nxt.rsp.exp = port_rdata[CNT_W-1:0];
                            endcase
                        end
                        K_POLL: begin
                            // Busy is up from the last setup access, so a clear read means done.
                            if (!port_rdata[BUSY_BIT]) begin
                                q_nxt.idx = q_r.idx + 4'h1;
                                q_nxt.seen_clear = 1'b1;
                            end
                        end
                        K_ACCCHK: begin
                            if (!port_rdata[MAC_BIT]) begin
                                q_nxt.idx = q_r.idx + 4'h1;
                                q_nxt.acc_ok = 1'b1;
                            end
                        end
                        default: begin
                            q_nxt.st = S_DONE;
                        end
                    endcase
                end
            end
            S_DONE: begin
                q_nxt.rsp_valid = 1'b1;
                q_nxt.st = S_IDLE;
            end
            default: begin
                q_nxt.st = S_IDLE;
            end
        endcase
    end

    // State register with clock enable.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q_r <= '0;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_ready = (q_r.st == S_IDLE);
    assign busy = (q_r.st != S_IDLE);
    assign rsp_valid = q_r.rsp_valid;
    assign rsp = q_r.rsp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b || !ce);

    // Multiply starts with the low multiplier byte on the second operand.
    property p_mul_start;
        cmd_valid && cmd_ready && cmd.op == OP_MUL |-> ##2
            (sfr_out.wr && sfr_out.addr == ADDR_OPB && sfr_out.wdata == q_r.cmd.b[7:0]);
    endproperty
    a_mul_start: assert property (p_mul_start) else $error("multiply start wrong");

    // Shift starts with the low data byte on the operand.
    property p_shift_start;
        cmd_valid && cmd_ready && cmd.op == OP_SHIFT |-> ##2
            (sfr_out.wr && sfr_out.addr == ADDR_OPA && sfr_out.wdata == q_r.cmd.a[7:0]);
    endproperty
    a_shift_start: assert property (p_shift_start) else $error("shift start wrong");

    // A short divide writes dividend low, high, then divisor low.
    sequence s_div16_writes;
        (sfr_out.wr && sfr_out.addr == ADDR_OPA && sfr_out.wdata == q_r.cmd.a[7:0]) ##2
        (sfr_out.wr && sfr_out.addr == ADDR_OPA && sfr_out.wdata == q_r.cmd.a[15:8]) ##2
        (sfr_out.wr && sfr_out.addr == ADDR_OPB && sfr_out.wdata == q_r.cmd.b[7:0]);
    endsequence
    property p_div16_order;
        cmd_valid && cmd_ready && cmd.op == OP_DIV16 |-> ##2 s_div16_writes;
    endproperty
    a_div16_order: assert property (p_div16_order) else $error("short divide order");

    // Normalize writes a zero count.
    property p_norm_zero;
        sfr_out.wr && sfr_out.addr == ADDR_SHIFT_CNT && q_r.cmd.op == OP_NORM
            |-> sfr_out.wdata[CNT_W-1:0] == 5'h00;
    endproperty
    a_norm_zero: assert property (p_norm_zero) else $error("normalize count not zero");

    // Remainder reads only follow a divide whose quotient is in.
    property p_rem_after_quot;
        sfr_out.rd && sfr_out.addr == ADDR_OPB |->
            (q_r.cmd.op == OP_DIV32 || q_r.cmd.op == OP_DIV16) && q_r.seen_clear;
    endproperty
    a_rem_after_quot: assert property (p_rem_after_quot) else $error("remainder early");

    // Results are read only after busy was seen clear.
    property p_read_after_poll;
        sfr_out.rd && sfr_out.addr == ADDR_OPA |-> q_r.seen_clear;
    endproperty
    a_read_after_poll: assert property (p_read_after_poll) else $error("read before done");

    // Accumulator access only after the status flag read clear.
    property p_acc_gate;
        (sfr_out.rd || sfr_out.wr) && sfr_out.addr == ADDR_ACC |-> q_r.acc_ok;
    endproperty
    a_acc_gate: assert property (p_acc_gate) else $error("accumulator not gated");

    // Accumulator load reads the status flag before any accumulator access.
    // The read strobe is registered, so it shows two edges after acceptance.
    property p_acc_load;
        cmd_valid && cmd_ready && cmd.op == OP_ACC_LOAD |-> ##2
            (sfr_out.rd && sfr_out.addr == ADDR_CTRL_STAT) ##0 !q_r.acc_ok;
    endproperty
    a_acc_load: assert property (p_acc_load) else $error("load not gated");

    // Each accumulator write carries the next command byte, low byte first.
    property p_acc_bytes;
        sfr_out.wr && sfr_out.addr == ADDR_ACC |->
            sfr_out.wdata == q_r.cmd.acc[8*(q_r.idx-4'h1) +: 8];
    endproperty
    a_acc_bytes: assert property (p_acc_bytes) else $error("accumulator byte order");

    // Restart clears the busy flag in the status register.
    property p_clear;
        cmd_valid && cmd_ready && cmd.op == OP_CLEAR |-> ##2
            (sfr_out.wr && sfr_out.addr == ADDR_CTRL_STAT && !sfr_out.wdata[BUSY_BIT]);
    endproperty
    a_clear: assert property (p_clear) else $error("clear write wrong");

    // Read and write strobes never overlap.
    property p_strobes;
        !(sfr_out.wr && sfr_out.rd);
    endproperty
    a_strobes: assert property (p_strobes) else $error("strobe overlap");

    // An answer comes with the controller idle and lasts one cycle.
    // A new command may be taken at the edge that ends the answer.
    property p_answer;
        rsp_valid |-> cmd_ready ##1 !rsp_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("answer pulse fault");

    c_mul: cover property (q_r.st == S_DONE && q_r.cmd.op == OP_MUL);
    c_div32: cover property (q_r.st == S_DONE && q_r.cmd.op == OP_DIV32);
    c_norm: cover property (q_r.st == S_DONE && q_r.cmd.op == OP_NORM);
    c_acc_read: cover property (q_r.st == S_DONE && q_r.cmd.op == OP_ACC_READ);

endmodule

// *** dv/msa_accel_model.sv ***
// Behavioural accelerator that answers the controller on its register port.
// Assumes a shared ref_clk; read data is wanted one cycle after the strobe.
`timescale 1ns/1ps
module msa_accel_model
    import msa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire msa_sfr_t sfr_out,
    input wire logic [3:0] extra,
    output logic [7:0] sfr_rdata
);
    logic [31:0] a, res;
    logic [15:0] b, rem;
    logic [39:0] acc;
    logic [4:0] ex, cnt;
    logic [2:0] na, nb, ai;
    logic [1:0] ri;
    logic bf, bsy, mac;
    logic [7:0] d;
    int n;

    // Starts an operation: the result is ready at once and busy covers the run time.
    task automatic go(logic m, int t, logic [31:0] r, logic [15:0] q,
                      logic [4:0] e, logic [1:0] p);
        {res, rem, ex, ri, bsy, mac} = {r, q, e, p, 1'b1, m};
        cnt = 5'(t) + {1'b0, extra};
        if (m) acc = acc + {8'h00, r};
        {na, nb, bf, ai} = '0;
    endtask

    // Each edge runs the countdown, then serves the access seen on the port.
    always @(posedge ref_clk) begin
        d = sfr_out.wdata;
        sfr_rdata <= ~sfr_rdata; // Released read data keeps toggling.
        if (bsy && cnt == 5'h0) {bsy, mac} = 2'b00;
        cnt = cnt - 5'h1;
        if (sfr_out.wr && sfr_out.addr == ADDR_OPA) begin
            a[8*na[1:0]+:8] = d;
            na = na + 3'd1;
            if (bf && na == 3'd2) go(1'b1, 6, 32'(a[15:0]) * b, 16'h0, 5'h0, 2'h3);
        end
        if (sfr_out.wr && sfr_out.addr == ADDR_OPB) begin
            b[8*nb[0]+:8] = d;
            nb = nb + 3'd1;
            bf = bf | (na == 3'd0);
            if (nb == 3'd2 && na == 3'd4) go(1'b1, 9, a / b, 16'(a % b), 5'h0, 2'h3);
            if (nb == 3'd2 && na == 3'd2)
                go(1'b1, 6, 32'(a[15:0] / b), 16'(a[15:0] % b), 5'h0, 2'h1);
        end
        if (sfr_out.wr && sfr_out.addr == ADDR_SHIFT_CNT && na == 3'd4) begin
            n = 0;
            while (n < 31 && !a[31-n]) n++;
            if (d == 8'h00) go(1'b0, 9, a << n, 16'h0, 5'(n), 2'h3);
            else go(1'b0, 9, d[5] ? a >> d[4:0] : a << d[4:0], 16'h0, 5'h0, 2'h3);
        end
        if (sfr_out.wr && sfr_out.addr == ADDR_CTRL_STAT && !d[BUSY_BIT])
            {na, nb, bf, bsy, mac, ai} = '0;
        if (sfr_out.wr && sfr_out.addr == ADDR_ACC) begin
            acc[8*ai+:8] = d;
            ai = (ai == 3'd4) ? 3'd0 : ai + 3'd1;
        end
        if (sfr_out.rd) begin
            case (sfr_out.addr)
                ADDR_OPA: sfr_rdata <= res[8*ri+:8] ^ {8{bsy}};
                ADDR_OPB: sfr_rdata <= rem[15:8];
                ADDR_SHIFT_CNT: sfr_rdata <= {3'h0, ex};
                ADDR_CTRL_STAT: sfr_rdata <= {bsy, mac, 6'h00};
                ADDR_ACC: sfr_rdata <= acc[8*(4-ai)+:8];
                default: ;
            endcase
            if (sfr_out.addr == ADDR_OPA) ri = ri - 2'h1;
            if (sfr_out.addr == ADDR_OPB) rem = rem << 8;
            if (sfr_out.addr == ADDR_ACC) ai = (ai == 3'd4) ? 3'd0 : ai + 3'd1;
        end
        if (!rst_b) begin
            {na, nb, bf, bsy, mac, ai, acc} = '0;
            sfr_rdata <= 8'h00;
        end
    end
endmodule

// *** dv/tb_sequenced_math_accelerator.sv ***
// Self-checking bench for the accelerator controller against the model accelerator.
// Assumes the package, the controller and the model are compiled first.
`timescale 1ns/1ps
module tb_sequenced_math_accelerator
    import msa_pkg::*;
    ;
    logic ref_clk, rst_b, ce, cmd_valid, cmd_ready, rsp_valid, busy;
    logic [7:0] sfr_rdata;
    logic [3:0] extra;
    logic [39:0] acc_m;
    msa_cmd_t cmd;
    msa_rsp_t rsp, want;
    msa_sfr_t sfr_out;
    int mismatches, tests_run, i;

    msa_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy),
        .sfr_out(sfr_out), .sfr_rdata(sfr_rdata));
    msa_accel_model i_acc (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_out(sfr_out),
        .extra(extra), .sfr_rdata(sfr_rdata));

    // Core clock.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Counts: tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(logic [127:0] g, logic [127:0] w);
        tests_run++;
        if (g !== w) begin
            mismatches++;
            $display("BAD at %0t got %h want %h", $time, g, w);
        end
    endtask

    // Expected response; also keeps the bench's own accumulator.
    function automatic msa_rsp_t expect_rsp(msa_cmd_t c);
        msa_rsp_t r;
        int n;
        r = '0;
        n = 0;
        case (c.op)
            OP_MUL: r.res = c.a[15:0] * c.b;
            OP_DIV32: {r.res, r.rem} = {c.a / c.b, 16'(c.a % c.b)};
            OP_DIV16: {r.res, r.rem} = {32'(c.a[15:0] / c.b), 16'(c.a[15:0] % c.b)};
            OP_SHIFT: r.res = c.dir ? c.a >> c.cnt : c.a << c.cnt;
            OP_NORM: begin
                while (n < 31 && !c.a[31-n]) n++;
                {r.res, r.exp} = {c.a << n, 5'(n)};
            end
            OP_ACC_LOAD: acc_m = c.acc;
            OP_ACC_READ: r.acc = acc_m;
            default: ;
        endcase
        if (c.op inside {OP_MUL, OP_DIV32, OP_DIV16}) acc_m = acc_m + {8'h00, r.res};
        return r;
    endfunction

    // Random command; nonzero divisor and value, shift count never zero.
    function automatic msa_cmd_t rnd(msa_op_t op);
        return '{op, ($urandom >> $urandom_range(31, 0)) | 32'h1,
            16'($urandom_range(65535, 1)), 5'($urandom_range(31, 1)), 1'($urandom),
            {8'($urandom), $urandom}};
    endfunction

    // Offers one command, then waits a bounded time for its single response pulse.
    task automatic run(msa_cmd_t c);
        int k;
        want = expect_rsp(c);
        cmd = c;
        cmd_valid = 1'b1;
        extra = 4'($urandom);
        for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge ref_clk);
        check(cmd_ready, 1'b1);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        check(busy, 1'b1);
        for (k = 0; k < 600 && rsp_valid !== 1'b1; k++) @(negedge ref_clk);
        check(rsp_valid, 1'b1);
        if (rsp_valid !== 1'b1) give_verdict();
        check(rsp, want);
        @(negedge ref_clk);
        check(rsp_valid, 1'b0);
    endtask

    // Reset, corner cases, then a random mix of every command.
    initial begin
        i = $urandom(58384);
        {rst_b, cmd_valid, extra, acc_m, mismatches, tests_run} = '0;
        ce = 1'b1;
        cmd = '0;
        repeat (12) @(negedge ref_clk);
        check({cmd_ready, busy, rsp_valid, rsp, sfr_out}, {3'b100, 93'h0, 18'h0});
        rst_b = 1'b1;
        ce = 1'b0;
        cmd = rnd(OP_MUL);
        cmd_valid = 1'b1;
        repeat (4) @(negedge ref_clk);
        check({busy, cmd_ready}, 2'b01);
        {ce, cmd_valid} = 2'b10;
        run('{OP_ACC_LOAD, 32'h0, 16'h1, 5'h1, 1'b0, 40'hff_ffff_0000});
        run('{OP_MUL, 32'hffff, 16'hffff, 5'h1, 1'b0, 40'h0});
        run('{OP_DIV32, 32'hffff_ffff, 16'h1, 5'h1, 1'b0, 40'h0});
        run('{OP_DIV16, 32'h1234_00ff, 16'hffff, 5'h1, 1'b0, 40'h0});
        run('{OP_ACC_READ, 32'h0, 16'h1, 5'h1, 1'b0, 40'h0});
        run('{OP_NORM, 32'h1, 16'h1, 5'h1, 1'b0, 40'h0});
        run('{OP_NORM, 32'h8000_0000, 16'h1, 5'h1, 1'b0, 40'h0});
        run('{OP_SHIFT, 32'h8000_0001, 16'h1, 5'h1f, 1'b1, 40'h0});
        run('{OP_SHIFT, 32'h8000_0001, 16'h1, 5'h1f, 1'b0, 40'h0});
        run('{OP_CLEAR, 32'h0, 16'h1, 5'h1, 1'b0, 40'h0});
        run('{OP_ACC_READ, 32'h0, 16'h1, 5'h1, 1'b0, 40'h0});
        for (i = 0; i < 60; i++) run(rnd(msa_op_t'($urandom_range(7, 0))));
        give_verdict();
    end
endmodule
